// *** core/cfg_aperture_defs.vh ***
// constants for the configuration aperture and option registers
`ifndef CFG_APERTURE_DEFS_VH
`define CFG_APERTURE_DEFS_VH
// register byte offsets in configuration space
`define FB_WINDOW_BASE_OFS   8'h14
`define EXP_ROM_BASE_OFS     8'h30
`define CHIP_OPTION_OFS      8'h40
// frame buffer window base layout
`define FBW_FIXED_BITS       32'h0000_0008
`define FBW_BASE_LSB         23
`define FBW_BASE_MASK        32'hFF80_0000
// option register field positions
`define OPT_IO_DECODE        8
`define OPT_INTERLEAVE       12
`define OPT_RFH_LSB          16
`define OPT_EPROM_WR         20
`define OPT_NO_PRESCALE      21
`define OPT_BOARD_LSB        24
`define OPT_NO_RETRY         29
`define OPT_BIOS_EN          30
`define OPT_BIG_ENDIAN       31
`define OPT_WRITE_MASK       32'hE03F_1100
// expansion rom base layout
`define ROM_BASE_MASK        32'hFFFF_0000
// refresh interval constants
`define RFH_UNIT_CYCLES      128
`define PRESCALE_DIV         4
// reset hold time for memory initialisation, in us and in 10 ns cycles
`define RESET_HOLD_US        200
`define CLOCK_MHZ            100
`define RESET_HOLD_CYCLES    (`RESET_HOLD_US * `CLOCK_MHZ)
// byte swap window inside the control aperture
`define SWAP_LO              14'h1C00
`define SWAP_HI              14'h1EFF
`endif

// *** core/strap_sync.v ***
// three-stage synchroniser for strap and pin inputs
`timescale 1ns/10ps
module strap_sync #(
    parameter W = 7
) (
    input  wire         clock,   // pci clock
    input  wire         rst_n,   // sync reset, active low
    input  wire [W-1:0] pin_in,  // asynchronous pins
    output reg  [W-1:0] pin_out  // filtered value
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    // a change counts once the second and third stages agree
    always @(posedge clock) begin
        if (!rst_n) begin
            s1_q    <= {W{1'b0}};
            s2_q    <= {W{1'b0}};
            s3_q    <= {W{1'b0}};
            pin_out <= {W{1'b0}};
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                pin_out <= s3_q;
            end
        end
    end
endmodule

// *** core/refresh_timer.v ***
// prescaled refresh interval timer
`timescale 1ns/10ps
`include "cfg_aperture_defs.vh"
module refresh_timer (
    input  wire       clock,       // graphics clock
    input  wire       rst_n,       // sync reset, active low
    input  wire [3:0] rfh_count,   // programmed refresh count
    input  wire       no_prescale, // bypass divide by four
    output reg        rfh_tick     // one-cycle refresh request pulse
);
    reg [1:0]  pre_q;
    reg [10:0] cnt_q;
    wire       pre_tick;
    wire [10:0] reload;
    // divide by four unless bypassed
    assign pre_tick = no_prescale | (pre_q == 2'd3);
    assign reload   = {rfh_count, 7'd0} + 11'd127; // (count+1)*128-1
    // interval counter, reloads on each request
    always @(posedge clock) begin
        if (!rst_n) begin
            pre_q    <= 2'd0;
            cnt_q    <= 11'd0;
            rfh_tick <= 1'b0; // forced inactive in reset
        end else begin
            pre_q    <= pre_q + 2'd1;
            rfh_tick <= 1'b0;
            if (pre_tick) begin
                if (cnt_q == 11'd0) begin
                    cnt_q    <= reload;
                    rfh_tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 11'd1;
                end
            end
        end
    end
endmodule

// *** core/cfg_aperture_regs.v ***
// configuration aperture, option and rom base registers with aperture decode
// Contract
// - frame window base bit 0 reads zero, memory space.
// - frame window base bits 2:1 read 00.
// - frame window base bit 3 reads one, prefetchable.
// - frame window base bits 31:23 writable, 8 Mbyte window start.
// - overlap priority: eprom, control, legacy window, frame aperture.
// - frame aperture unavailable while native mode bit is zero.
// - hard reset loads bit 8 from legacy boot strap.
// - control and frame apertures decode regardless of io enable.
// - refresh every (count+1)*128 prescaled clocks.
// - refresh served at page break, transfer end or idle.
// - refresh request held inactive during reset.
// - eprom writes program only when write enable set.
// - prescale bypass zero divides graphics clock by four.
// - board option bits 28:24 hold sampled pins, read only.
// - retry disable stops retries in initial data phase.
// - bios enable gates expansion rom space.
// - swap bit byte-swaps control window 1C00 to 1EFF.
// - option reserved bits ignore writes, read zero.
// - rom base writable only with bios enable, else reads zero.
// - memory responses only when memory space enable set.
`timescale 1ns/10ps
`include "cfg_aperture_defs.vh"
module cfg_aperture_regs #(
    parameter RESET_HOLD = `RESET_HOLD_CYCLES
) (
    input  wire        clock,          // pci clock
    input  wire        rst_n,          // hard reset, sync, active low
    input  wire        cfg_wr,         // configuration write strobe
    input  wire        cfg_rd,         // configuration read strobe
    input  wire [7:0]  cfg_addr,       // configuration byte offset
    input  wire [3:0]  cfg_be,         // byte enables
    input  wire [31:0] cfg_wdata,      // write data
    output reg  [31:0] cfg_rdata,      // read data
    input  wire [4:0]  memory_data_pins, // board option pins
    input  wire        legacy_boot_strap, // legacy boot strap pin
    input  wire        memspace_en,    // memory space enable from device control
    input  wire        native_mode,    // extended display control bit 7
    input  wire [31:0] control_window_base, // control aperture base
    input  wire        mem_req,        // memory access request
    input  wire        mem_wr,         // request is a write
    input  wire [31:0] mem_addr,       // access address
    input  wire        legacy_fb_hit,  // legacy frame window hit
    input  wire        first_phase,    // initial data phase of transfer
    input  wire        want_retry,     // target would retry
    output reg  [3:0]  mem_sel,        // one-hot eprom,ctrl,legacy,frame
    output reg         eprom_prog,     // eprom write allowed
    output reg         byte_swap,      // swap bytes of this access
    output reg         retry_ok,       // retry may be issued
    output wire        legacy_io_decode, // legacy io decode enable
    output wire        interleave_en,  // interleave mode
    input  wire        page_break,     // drawing page break
    input  wire        xfer_done,      // data transfer finished
    input  wire        mc_idle,        // memory controller idle
    input  wire        xfer_req,       // data transfer request pending
    output reg         refresh_go,     // refresh granted to controller
    output reg         init_done       // set on the fifth edge after reset release; reset length is not checked
);
    // ********************************
    // registers
    // ********************************
    reg [31:0] fbw_q;
    reg [31:0] opt_q;
    reg [31:0] rom_q;
    reg [1:0]  pend_q;
    reg        rst_seen_q;
    reg [31:0] hold_q;
    reg        strap_ld_q;
    wire [5:0] pins_s;
    wire       tick;
    wire [31:0] fbw_rd;
    wire [31:0] opt_rd;
    wire [31:0] rom_rd;

    // byte-enable merge used by every configuration register write
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        input [31:0] mask;
        integer i;
        reg [31:0] m;
        begin
            m = 32'h0000_0000;
            for (i = 0; i < 4; i = i + 1) begin
                m[i*8 +: 8] = {8{be[i]}};
            end
            m = m & mask;
            merge = (old & ~m) | (nw & m);
        end
    endfunction

    // ********************************
    // pin synchronisers and refresh timer
    // ********************************
    strap_sync #(.W(6)) u_sync (
        .clock   (clock),
        .rst_n   (rst_n),
        .pin_in  ({legacy_boot_strap, memory_data_pins}),
        .pin_out (pins_s)
    );

    refresh_timer u_rfh (
        .clock       (clock),
        .rst_n       (rst_n),
        .rfh_count   (opt_q[`OPT_RFH_LSB +: 4]),
        .no_prescale (opt_q[`OPT_NO_PRESCALE]),
        .rfh_tick    (tick)
    );

    // ********************************
    // register writes
    // ********************************
    // straps are loaded a few edges after reset, once the synchroniser settled
    always @(posedge clock) begin
        if (!rst_n) begin
            fbw_q      <= 32'h0000_0000;
            opt_q      <= 32'h0000_0000;
            rom_q      <= 32'h0000_0000;
            rst_seen_q <= 1'b1;
            hold_q     <= 32'h0000_0000;
            strap_ld_q <= 1'b0;
        end else begin
            if (hold_q < 32'd4) begin
                hold_q <= hold_q + 32'd1;
            end else if (rst_seen_q) begin
                rst_seen_q <= 1'b0;
                strap_ld_q <= 1'b1;
                opt_q[`OPT_IO_DECODE] <= pins_s[5];
                opt_q[`OPT_BOARD_LSB +: 5] <= pins_s[4:0];
            end
            if (cfg_wr && !rst_seen_q) begin
                case (cfg_addr)
                    `FB_WINDOW_BASE_OFS: begin
                        fbw_q <= merge(fbw_q, cfg_wdata, cfg_be, `FBW_BASE_MASK);
                    end
                    `CHIP_OPTION_OFS: begin
                        opt_q <= merge(opt_q, cfg_wdata, cfg_be, `OPT_WRITE_MASK);
                    end
                    `EXP_ROM_BASE_OFS: begin
                        if (opt_q[`OPT_BIOS_EN]) begin
                            rom_q <= merge(rom_q, cfg_wdata, cfg_be, `ROM_BASE_MASK);
                        end
                    end
                    default: begin
                        rom_q <= rom_q;
                    end
                endcase
            end
        end
    end

    // ********************************
    // read path
    // ********************************
    assign fbw_rd = (fbw_q & `FBW_BASE_MASK) | `FBW_FIXED_BITS;
    assign opt_rd = opt_q;
    assign rom_rd = opt_q[`OPT_BIOS_EN] ? (rom_q & `ROM_BASE_MASK) : 32'h0000_0000;

    // read data registered; unmapped offsets read zero
    always @(posedge clock) begin
        if (!rst_n) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (cfg_rd) begin
            case (cfg_addr)
                `FB_WINDOW_BASE_OFS: cfg_rdata <= fbw_rd;
                `CHIP_OPTION_OFS:    cfg_rdata <= opt_rd;
                `EXP_ROM_BASE_OFS:   cfg_rdata <= rom_rd;
                default:             cfg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    assign legacy_io_decode = opt_q[`OPT_IO_DECODE];
    assign interleave_en    = opt_q[`OPT_INTERLEAVE];

    // ********************************
    // aperture decode
    // ********************************
    reg hit_rom;
    reg hit_ctl;
    reg hit_fb;
    reg [13:0] ctl_off;
    // priority chain resolves overlaps; apertures ignore io enable
    always @* begin
        hit_rom = opt_q[`OPT_BIOS_EN] &&
                  (mem_addr[31:16] == rom_q[31:16]);
        hit_ctl = (mem_addr[31:14] == control_window_base[31:14]);
        hit_fb  = native_mode && (mem_addr[31:23] == fbw_q[31:23]);
        ctl_off = mem_addr[13:0];
        mem_sel = 4'b0000;
        if (mem_req && memspace_en) begin
            if (hit_rom) begin
                mem_sel = 4'b0001;
            end else if (hit_ctl) begin
                mem_sel = 4'b0010;
            end else if (legacy_fb_hit) begin
                mem_sel = 4'b0100;
            end else if (hit_fb) begin
                mem_sel = 4'b1000;
            end
        end
        eprom_prog = mem_sel[0] && mem_wr && opt_q[`OPT_EPROM_WR];
        byte_swap  = mem_sel[1] && opt_q[`OPT_BIG_ENDIAN] &&
                     (ctl_off >= `SWAP_LO) && (ctl_off <= `SWAP_HI);
        retry_ok   = want_retry && !(first_phase && opt_q[`OPT_NO_RETRY]);
    end

    // ********************************
    // refresh arbitration
    // ********************************
    // requests queue up to two; a second queued one preempts all but transfers
    always @(posedge clock) begin
        if (!rst_n) begin
            pend_q     <= 2'd0;
            refresh_go <= 1'b0;
            init_done  <= 1'b0;
        end else begin
            refresh_go <= 1'b0;
            if (hold_q >= 32'd4) begin
                init_done <= 1'b1;
            end
            if ((pend_q != 2'd0) &&
                (page_break || xfer_done || mc_idle ||
                 (pend_q == 2'd2 && !xfer_req))) begin
                refresh_go <= 1'b1;
                pend_q     <= pend_q - 2'd1 + {1'b0, (tick && pend_q != 2'd2)};
            end else if (tick && pend_q != 2'd2) begin
                pend_q <= pend_q + 2'd1;
            end
        end
    end
endmodule

// *** verif/cfg_host_model.sv ***
// host bridge model issuing configuration writes and read-backs
`timescale 1ns/10ps
module cfg_host_model (
    input  wire logic        clock,       // pci clock
    input  wire logic        native_mode, // current display mode
    input  wire logic [31:0] cfg_rdata,   // read data
    output logic             cfg_wr,      // write strobe
    output logic             cfg_rd,      // read strobe
    output logic [7:0]       cfg_addr,    // byte offset
    output logic [3:0]       cfg_be,      // byte enables
    output logic [31:0]      cfg_wdata    // write data
);
    // idle bus before the first access
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end
    // write then read back; answer is taken the cycle after the read strobe
    task access(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                output logic [31:0] q);
        begin
            @(negedge clock);
            cfg_addr = a;
            cfg_be = b;
            cfg_wr = 1'b1;
            // software keeps interleave off in legacy mode
            cfg_wdata = (a == 8'h40 && !native_mode) ? (d & ~32'h0000_1000) : d;
            @(negedge clock);
            cfg_wr = 1'b0;
            cfg_rd = 1'b1;
            // stale data is inverted so it never looks valid
            cfg_wdata = ~cfg_wdata;
            @(negedge clock);
            cfg_rd = 1'b0;
            q = cfg_rdata;
        end
    endtask
endmodule

// *** verif/cfg_aperture_regs_sva.sv ***
// assertions on the configuration aperture register ports
`timescale 1ns/10ps
module cfg_aperture_regs_sva (
    input wire logic        clock,               // pci clock
    input wire logic        rst_n,               // sync reset, low
    input wire logic        cfg_wr,              // write strobe
    input wire logic        cfg_rd,              // read strobe
    input wire logic [7:0]  cfg_addr,            // byte offset
    input wire logic [3:0]  cfg_be,              // byte enables
    input wire logic [31:0] cfg_wdata,           // write data
    input wire logic [31:0] cfg_rdata,           // read data
    input wire logic        memspace_en,         // memory space enable
    input wire logic        native_mode,         // native mode bit
    input wire logic [31:0] control_window_base, // control base
    input wire logic [31:0] mem_addr,            // access address
    input wire logic        legacy_fb_hit,       // legacy window hit
    input wire logic        first_phase,         // initial data phase
    input wire logic [3:0]  mem_sel,             // decode select
    input wire logic        byte_swap,           // swap enable
    input wire logic        retry_ok,            // retry allowed
    input wire logic        refresh_go           // refresh grant
);
    // shadow of the option top byte; tracks swap, bios and retry bits
    logic [7:0] opt_hi_q;
    always @(posedge clock) begin
        if (!rst_n)
            opt_hi_q <= 8'h00;
        else if (cfg_wr && cfg_addr == 8'h40 && cfg_be[3])
            opt_hi_q <= cfg_wdata[31:24];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence rd_fbw; cfg_rd && cfg_addr == 8'h14; endsequence
    sequence rd_opt; cfg_rd && cfg_addr == 8'h40; endsequence
    sequence rd_rom; cfg_rd && cfg_addr == 8'h30 && !opt_hi_q[6]; endsequence
    a_fbw_fixed_bits: assert property (rd_fbw |=> cfg_rdata[22:0] == 23'h08)
        else $error("frame window low bits wrong");
    a_opt_reserved_zero: assert property (rd_opt |=> (cfg_rdata & 32'h00C0_EEFF) == 0)
        else $error("option reserved bits not zero");
    a_rom_gated_zero: assert property (rd_rom |=> cfg_rdata == 32'h0000_0000)
        else $error("rom base readable while bios off");
    a_refresh_quiet_reset: assert property (@(posedge clock) $past(!rst_n) |-> !refresh_go)
        else $error("refresh during reset");
    a_memspace_gates_sel: assert property (!memspace_en |-> mem_sel == 4'h0)
        else $error("decode while memory space off");
    a_frame_needs_native: assert property (!native_mode |-> !mem_sel[3])
        else $error("frame aperture in legacy mode");
    a_sel_one_hot: assert property ($onehot0(mem_sel) && !(mem_sel[3] && legacy_fb_hit))
        else $error("decode priority broken");
    a_swap_window_only: assert property (byte_swap |-> opt_hi_q[7]
        && mem_addr[31:14] == control_window_base[31:14]
        && mem_addr[13:0] >= 14'h1C00 && mem_addr[13:0] <= 14'h1EFF)
        else $error("swap outside window");
    a_retry_blocked: assert property (first_phase && opt_hi_q[5] |-> !retry_ok)
        else $error("retry in first phase");
endmodule
bind cfg_aperture_regs cfg_aperture_regs_sva cfg_aperture_regs_sva_inst (
    .clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .memspace_en(memspace_en),
    .native_mode(native_mode), .control_window_base(control_window_base), .mem_addr(mem_addr),
    .legacy_fb_hit(legacy_fb_hit), .first_phase(first_phase), .mem_sel(mem_sel),
    .byte_swap(byte_swap), .retry_ok(retry_ok), .refresh_go(refresh_go));

// *** verif/cfg_aperture_regs_bench.sv ***
// self-checking bench for the configuration aperture registers
`timescale 1ns/10ps
module cfg_aperture_regs_bench;
    typedef struct packed {logic [7:0] a; logic [3:0] b; logic [31:0] d; logic [31:0] e;} row_t;
    logic clock, rst_n, cfg_wr, cfg_rd, boot, memspace_en, native_mode, legacy_fb_hit;
    logic first_phase, mem_req, byte_swap, retry_ok, legacy_io_decode, interleave_en, refresh_go;
    logic mem_wr, want_retry, eprom_prog, init_done;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be, mem_sel;
    logic [31:0] cfg_wdata, cfg_rdata, mem_addr, q, r;
    row_t        rows [12];
    int          n_fail, num_checks, i, n;
    cfg_host_model host (.clock(clock), .native_mode(native_mode), .cfg_rdata(cfg_rdata),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
    cfg_aperture_regs cfg_aperture_regs_inst (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .memory_data_pins(5'h15), .legacy_boot_strap(boot),
        .memspace_en(memspace_en), .native_mode(native_mode),
        .control_window_base(32'h1000_0000), .mem_req(mem_req), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .legacy_fb_hit(legacy_fb_hit), .first_phase(first_phase),
        .want_retry(want_retry), .mem_sel(mem_sel), .eprom_prog(eprom_prog), .byte_swap(byte_swap),
        .retry_ok(retry_ok), .legacy_io_decode(legacy_io_decode), .interleave_en(interleave_en),
        .page_break(1'b0), .xfer_done(1'b0), .mc_idle(mem_req), .xfer_req(1'b0),
        .refresh_go(refresh_go), .init_done(init_done));
    // clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // reset held six cycles, then wait past the strap load
    task do_reset;
        @(negedge clock);
        rst_n = 1'b0;
        repeat (6) @(negedge clock);
        check("quiet in reset", refresh_go, 0);
        check("init held off", init_done, 0);
        rst_n = 1'b1;
        repeat (8) @(negedge clock);
        check("init done", init_done, 1);
    endtask
    // count cycles to the next refresh grant; a lost grant ends the run
    task next_go(output int c);
        c = 0;
        do begin
            @(negedge clock);
            c++;
        end while (refresh_go !== 1'b1 && c < 3000);
        if (c >= 3000) begin
            n_fail++;
            finish_test;
        end
    endtask
    initial begin
        {rst_n, boot, memspace_en, native_mode, legacy_fb_hit, first_phase, mem_req} = 7'b0111000;
        mem_addr = 32'h0000_0000;
        mem_wr = 1'b0;
        want_retry = 1'b1;
        n_fail = 0;
        num_checks = 0;
        rows = '{'{8'h14, 4'hF, 32'hFFFF_FFFF, 32'hFF80_0008}, '{8'h14, 4'hF, 0, 32'h0000_0008},
            '{8'h14, 4'h8, 32'hA5A5_A5A5, 32'hA500_0008}, '{8'h40, 4'hF, 32'hFFFF_FFFF, 32'hF53F_1100},
            '{8'h40, 4'hF, 0, 32'h1500_0000}, '{8'h30, 4'hF, 32'hFFFF_FFFF, 0},
            '{8'h40, 4'hF, 32'h4000_0000, 32'h5500_0000}, '{8'h30, 4'hF, 32'h1234_5678, 32'h1234_0000},
            '{8'h30, 4'h4, 32'hABAB_ABAB, 32'h12AB_0000}, '{8'h40, 4'hF, 32'h0000_0100, 32'h1500_0100},
            '{8'h30, 4'h0, 0, 0}, '{8'h20, 4'hF, 32'hFFFF_FFFF, 0}};
        do_reset;
        host.access(8'h40, 4'h0, 0, q);
        check("strap option", q, 32'h1500_0100);
        check("io decode", legacy_io_decode, 1);
        foreach (rows[k]) begin
            host.access(rows[k].a, rows[k].b, rows[k].d, q);
            check("readback", q, rows[k].e);
        end
        // swap window edges and retry suppression, option value in d
        memspace_en = 1'b1;
        mem_req = 1'b1;
        rows = '{'{0, 1, 32'h8000_0000, 32'h1000_1C00}, '{0, 1, 32'h8000_0000, 32'h1000_1EFF},
            '{0, 1, 32'hA000_0000, 32'h1000_1F00}, '{0, 0, 32'hA000_0000, 32'h1000_1BFF},
            '{0, 1, 32'h0000_1000, 32'h1000_1C00}, '{0, 1, 32'h0000_1000, 32'h1000_1C00},
            '{0, 1, 32'h0000_1000, 32'h1000_1C00}, '{0, 1, 32'h0000_1000, 32'h1000_1C00},
            '{0, 1, 32'h0000_1000, 32'h1000_1C00}, '{0, 1, 32'h0000_1000, 32'h1000_1C00},
            '{0, 1, 32'h0000_1000, 32'h1000_1C00}, '{0, 1, 32'h0000_1000, 32'h1000_1C00}};
        for (i = 0; i < 5; i++) begin
            host.access(8'h40, 4'hF, rows[i].d, q);
            first_phase = rows[i].b[0];
            mem_addr = rows[i].e;
            #1;
            check("swap", byte_swap, (i < 2));
            check("retry", retry_ok, (i != 2));
            check("interleave", interleave_en, rows[i].d[12]);
        end
        // no retry offered when the target does not want one
        want_retry = 1'b0;
        #1;
        check("retry unwanted", retry_ok, 0);
        // decode: {memspace, native, legacy hit} against the expected select
        rows[0:3] = '{'{8'h6, 4'h8, 0, 0}, '{8'h2, 4'h0, 0, 0}, '{8'h7, 4'h4, 0, 0}, '{8'h3, 0, 0, 0}};
        mem_addr = 32'hA500_1000;
        for (i = 0; i < 4; i++) begin
            {memspace_en, native_mode, legacy_fb_hit} = rows[i].a[2:0];
            #1;
            check("select", mem_sel, rows[i].b);
        end
        // eprom wins over the legacy hit; programming follows its write enable
        memspace_en = 1'b1;
        mem_wr = 1'b1;
        mem_addr = 32'h12AB_0040;
        for (i = 0; i < 2; i++) begin
            host.access(8'h40, 4'hF, {1'b0, 1'b1, 9'h0, i == 0, 20'h0}, q);
            #1;
            check("eprom select", mem_sel, 4'h1);
            check("eprom program", eprom_prog, (i == 0));
        end
        // refresh spacing: count 0 bypass, count 1 bypass, count 0 divided
        for (i = 0; i < 3; i++) begin
            host.access(8'h40, 4'hF, {10'h0, i != 2, 1'b0, 3'h0, i == 1, 16'h0}, q);
            next_go(n);
            next_go(n);
            next_go(n);
            check("refresh gap", n, (i == 0) ? 128 : ((i == 1) ? 256 : 512));
        end
        // second reset with the strap low replaces the written enable
        boot = 1'b0;
        do_reset;
        host.access(8'h40, 4'h0, 0, q);
        check("strap reload", q, 32'h1500_0000);
        check("io decode off", legacy_io_decode, 0);
        finish_test;
    end
endmodule
